//--- include/amf_pkg.sv
// package of constants for the amplifier mode and fault controller
package amf_pkg;
   // i2c slave address (7 bit) from write byte 0xD8
   localparam logic [6:0] I2C_ADDR = 7'h6C;
   // subaddresses
   localparam logic [7:0] SUB_FAULT = 8'h01;
   localparam logic [7:0] SUB_STATUS = 8'h02;
   localparam logic [7:0] SUB_CTRL = 8'h03;
   // value read beyond defined registers
   localparam logic [7:0] UNMAPPED_VAL = 8'h00;
   // reset values
   localparam logic [7:0] FAULT_RST = 8'h00;
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [7:0] CTRL_RST = 8'h78;
   localparam logic [7:0] SUBADDR_RST = 8'h00;
   // fault register bit positions
   localparam int FB_DIAG = 2;
   localparam int FB_OC = 3;
   localparam int FB_UV = 4;
   localparam int FB_OV = 5;
   localparam int FB_DC = 6;
   localparam int FB_OT = 7;
   // status register bit positions
   localparam int SB_SH_PWR = 0;
   localparam int SB_SH_GND = 1;
   localparam int SB_OPEN = 2;
   localparam int SB_SHORT = 3;
   localparam int SB_FAULT = 4;
   localparam int SB_DIAG = 5;
   localparam int SB_MUTE = 6;
   localparam int SB_PLAY = 7;
   // wake delay after standby release
   localparam int CLK_MHZ = 125;
   localparam int WAKE_US = 1000;
   localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
   // operating states, one-hot
   typedef enum logic [3:0] {
      ST_STANDBY = 4'b0001,
      ST_DIAG = 4'b0010,
      ST_MUTE = 4'b0100,
      ST_PLAY = 4'b1000
   } amf_state_t;
endpackage : amf_pkg

//--- logic/amf_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module amf_sync #(
   parameter int W = 1
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] meta_q; // first stage, read only by second
   // double register
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         meta_q <= '0;
         o_q <= '0;
      end else begin
         meta_q <= i_d;
         o_q <= meta_q;
      end
   end
endmodule : amf_sync

//--- logic/amf_ctrl.sv
// mode sequencer, fault latch and i2c slave of a mono amplifier
// Summary of operation
// - sequential read auto-increments subaddress per byte
// - alert pin low while fault forces hi-z
// - fault cause readable over i2c
// - standby pin low means full shutdown
// - shutdown: i2c released, registers reset
// - mute pin stops switching; release resumes play
// - standby: hi-z, oscillator stopped, port idle
// - diagnostic: dc bias, oscillator, i2c active
// - mute or fault: hi-z, port active
// - play: switching outputs, port active
// - protection faults report and hard-mute hi-z
// - oc/dc in play; voltage/thermal mute+play
// - diag via i2c; short re-runs, open clears
// - slave address write D8, read D9
// - i2c usable about 1 ms after wake
// - fault, status, control at subaddresses 1-3
// - after power-on reset restart with defaults
`timescale 1ns/10ps
module amf_ctrl #(
   parameter int WAKE_CYCLES = amf_pkg::WAKE_CYC
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   input wire logic i_standby_b, // shutdown pin, low = standby
   input wire logic i_mute, // mute pin, high = mute
   input wire logic i_supply_low_fault, // supply undervoltage
   input wire logic i_supply_high_fault, // overvoltage / load dump
   input wire logic i_overtemp_shutdown,
   input wire logic i_overcurrent_shutdown,
   input wire logic i_dc_offset,
   input wire logic i_diag_done, // pulse: diagnostic cycle finished
   input wire logic [3:0] i_diag_result, // {short, open, gnd, pwr}
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_oe, // high while pulling sda low
   output logic o_sda_out,
   output logic o_alert_oe, // high while pulling alert low
   output logic o_alert_out,
   output logic o_osc_en,
   output logic o_out_switch, // outputs switching with audio
   output logic o_out_bias, // outputs dc biased
   output logic o_diag_run,
   output logic [7:0] o_ctrl
);
   ////////////////////////////////////////////////////////////////
   // input synchronisers
   logic [8:0] sync_w;
   amf_sync #(.W(9)) u_sync (
      .i_sys_clk(i_sys_clk),
      .i_rst_b(i_rst_b),
      .i_d({i_standby_b, i_mute, i_supply_low_fault, i_supply_high_fault,
            i_overtemp_shutdown, i_overcurrent_shutdown, i_dc_offset, i_scl, i_sda}),
      .o_q(sync_w)
   );
   wire stby_b = sync_w[8];
   wire mute = sync_w[7];
   wire uv = sync_w[6];
   wire ov = sync_w[5];
   wire ot = sync_w[4];
   wire oc = sync_w[3];
   wire dc = sync_w[2];
   wire scl = sync_w[1];
   wire sda = sync_w[0];

   ////////////////////////////////////////////////////////////////
   // state machine
   amf_pkg::amf_state_t st_q;
   amf_pkg::amf_state_t st_d;
   logic [17:0] wake_q; // port-enable delay counter
   logic port_en_q; // i2c usable
   // fault monitoring, gated per state
   wire volt_therm = uv | ov | ot;
   wire chan_flt = (st_q == amf_pkg::ST_PLAY) & (oc | dc);
   wire mon = (st_q == amf_pkg::ST_MUTE) | (st_q == amf_pkg::ST_PLAY);
   // holds a channel fault past the drop to mute, else mute/play would chatter
   logic chan_hold_q;
   wire prot_flt = (mon & volt_therm) | chan_flt | chan_hold_q;
   wire diag_short = i_diag_done & (i_diag_result[3] | i_diag_result[1] | i_diag_result[0]);
   // next state
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         amf_pkg::ST_STANDBY: if (port_en_q) st_d = amf_pkg::ST_DIAG;
         // voltage/thermal faults abort diagnostics; short re-runs them
         amf_pkg::ST_DIAG: if (volt_therm) st_d = amf_pkg::ST_MUTE;
            else if (i_diag_done && !diag_short) st_d = amf_pkg::ST_MUTE;
         amf_pkg::ST_MUTE: if (!mute && !prot_flt) st_d = amf_pkg::ST_PLAY;
         amf_pkg::ST_PLAY: if (mute || prot_flt) st_d = amf_pkg::ST_MUTE;
         default: st_d = amf_pkg::ST_STANDBY;
      endcase
      if (!stby_b) st_d = amf_pkg::ST_STANDBY;
   end
   // state and wake counter; standby and power reset clear all
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_q <= amf_pkg::ST_STANDBY;
         wake_q <= '0;
         port_en_q <= 1'b0;
         chan_hold_q <= 1'b0;
      end else begin
         st_q <= st_d;
         // released once the channel cause is gone
         chan_hold_q <= stby_b & (chan_flt | chan_hold_q & (oc | dc));
         if (!stby_b) begin
            wake_q <= '0;
            port_en_q <= 1'b0;
         end else if (!port_en_q) begin
            wake_q <= wake_q + 18'd1;
            port_en_q <= (wake_q >= 18'(WAKE_CYCLES - 1));
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // registers
   logic [7:0] fault_q, diag_q, ctrl_q, sub_q;
   logic wr_w; // one-cycle data write strobe
   logic [7:0] wdat_w;
   logic sub_ld_w, sub_inc_w;
   wire [7:0] status_w = {st_q == amf_pkg::ST_PLAY, st_q == amf_pkg::ST_MUTE,
                          st_q == amf_pkg::ST_DIAG, prot_flt, diag_q[3:0]};
   // read mux with fixed value beyond map
   wire [7:0] rd_w = (sub_q == amf_pkg::SUB_FAULT) ? fault_q :
                     (sub_q == amf_pkg::SUB_STATUS) ? status_w :
                     (sub_q == amf_pkg::SUB_CTRL) ? ctrl_q : amf_pkg::UNMAPPED_VAL;
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         fault_q <= amf_pkg::FAULT_RST;
         diag_q <= amf_pkg::STATUS_RST;
         ctrl_q <= amf_pkg::CTRL_RST;
         sub_q <= amf_pkg::SUBADDR_RST;
      end else if (!stby_b) begin
         fault_q <= amf_pkg::FAULT_RST;
         diag_q <= amf_pkg::STATUS_RST;
         ctrl_q <= amf_pkg::CTRL_RST;
         sub_q <= amf_pkg::SUBADDR_RST;
      end else begin
         // latched cause, sticky until standby
         fault_q[amf_pkg::FB_OC] <= fault_q[amf_pkg::FB_OC] | chan_flt & oc;
         fault_q[amf_pkg::FB_DC] <= fault_q[amf_pkg::FB_DC] | chan_flt & dc;
         fault_q[amf_pkg::FB_UV] <= fault_q[amf_pkg::FB_UV] | mon & uv;
         fault_q[amf_pkg::FB_OV] <= fault_q[amf_pkg::FB_OV] | mon & ov;
         fault_q[amf_pkg::FB_OT] <= fault_q[amf_pkg::FB_OT] | mon & ot;
         fault_q[amf_pkg::FB_DIAG] <= fault_q[amf_pkg::FB_DIAG] | diag_short;
         if (i_diag_done) diag_q <= {4'h0, i_diag_result};
         if (wr_w && sub_q == amf_pkg::SUB_CTRL) ctrl_q <= wdat_w;
         if (sub_ld_w) sub_q <= wdat_w;
         else if (sub_inc_w) sub_q <= sub_q + 8'd1;
      end
   end

   ////////////////////////////////////////////////////////////////
   // i2c slave
   typedef enum logic [4:0] {
      I_IDLE = 5'b00001, I_RX = 5'b00010, I_ACK = 5'b00100,
      I_TX = 5'b01000, I_MACK = 5'b10000
   } amf_i2c_t;
   amf_i2c_t is_q;
   logic scl_q, sda_q; // previous synchronised levels
   logic [7:0] sh_q;
   logic [2:0] bit_q;
   logic [1:0] byte_q; // 0 addr, 1 sub, 2+ data
   logic rd_q, ack_q;
   wire rise = scl & ~scl_q;
   wire fall = ~scl & scl_q;
   wire start = scl & scl_q & sda_q & ~sda;
   wire stop = scl & scl_q & ~sda_q & sda;
   wire [7:0] rxb = {sh_q[6:0], sda};
   wire addr_ok = (rxb[7:1] == amf_pkg::I2C_ADDR);
   assign wr_w = is_q == I_RX && rise && bit_q == 3'd7 && byte_q[1];
   assign wdat_w = rxb;
   assign sub_ld_w = is_q == I_RX && rise && bit_q == 3'd7 && byte_q == 2'd1;
   // auto-increment after each sent byte and after each written byte
   assign sub_inc_w = (is_q == I_MACK && rise) || wr_w;
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         is_q <= I_IDLE; scl_q <= 1'b1; sda_q <= 1'b1; sh_q <= '0;
         bit_q <= '0; byte_q <= '0; rd_q <= 1'b0; ack_q <= 1'b0;
         o_sda_oe <= 1'b0;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
         if (!port_en_q || !stby_b) begin
            is_q <= I_IDLE; // never holds bus
            o_sda_oe <= 1'b0;
         end else if (stop) begin
            is_q <= I_IDLE;
            o_sda_oe <= 1'b0;
         end else if (start) begin
            is_q <= I_RX; bit_q <= '0; byte_q <= '0; o_sda_oe <= 1'b0;
         end else unique case (is_q)
            I_IDLE: o_sda_oe <= 1'b0;
            I_RX: if (rise) begin
               sh_q <= rxb; bit_q <= bit_q + 3'd1;
               if (bit_q == 3'd7) begin
                  ack_q <= (byte_q != 2'd0) | addr_ok;
                  if (byte_q == 2'd0) rd_q <= rxb[0];
                  is_q <= I_ACK;
               end
            end
            I_ACK: if (fall) begin
               if (!ack_q) is_q <= I_IDLE;
               else if (o_sda_oe) begin
                  o_sda_oe <= 1'b0;
                  if (byte_q != 2'd3) byte_q <= byte_q + 2'd1;
                  if (rd_q && byte_q == 2'd0) begin
                     is_q <= I_TX; sh_q <= rd_w; o_sda_oe <= ~rd_w[7]; bit_q <= 3'd1;
                  end else is_q <= I_RX;
               end else o_sda_oe <= 1'b1;
            end
            I_TX: if (fall) begin
               if (bit_q == 3'd0) begin o_sda_oe <= 1'b0; is_q <= I_MACK; end
               else begin o_sda_oe <= ~sh_q[3'd7 - bit_q]; bit_q <= bit_q + 3'd1; end
            end
            // master nack ends read
            I_MACK: if (rise) is_q <= sda ? I_IDLE : I_MACK;
               else if (fall) begin
                  is_q <= I_TX; sh_q <= rd_w; o_sda_oe <= ~rd_w[7]; bit_q <= 3'd1;
               end
            default: is_q <= I_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // output stage and alert, all registered
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_alert_oe <= 1'b0; o_osc_en <= 1'b0; o_out_switch <= 1'b0;
         o_out_bias <= 1'b0; o_diag_run <= 1'b0; o_ctrl <= amf_pkg::CTRL_RST;
         o_sda_out <= 1'b0; o_alert_out <= 1'b0;
      end else begin
         // open-drain pins only ever pull low
         o_sda_out <= 1'b0;
         o_alert_out <= 1'b0;
         o_alert_oe <= stby_b & prot_flt;
         o_osc_en <= st_d != amf_pkg::ST_STANDBY;
         o_out_switch <= st_d == amf_pkg::ST_PLAY && !prot_flt;
         o_out_bias <= st_d == amf_pkg::ST_DIAG;
         o_diag_run <= st_d == amf_pkg::ST_DIAG;
         o_ctrl <= ctrl_q;
      end
   end

   ////////////////////////////////////////////////////////////////
   // checks
   a_stby_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      !stby_b |=> !o_out_switch && !o_osc_en) else $error("active in standby");
   a_stby_sda: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      !stby_b |=> !o_sda_oe) else $error("sda held in standby");
   a_stby_regs: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      !stby_b |=> ctrl_q == amf_pkg::CTRL_RST && fault_q == amf_pkg::FAULT_RST)
      else $error("regs not reset");
   a_alert_flt: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      stby_b && prot_flt |=> o_alert_oe) else $error("alert missing");
   a_alert_rel: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      !prot_flt |=> !o_alert_oe) else $error("alert stuck");
   a_mute_stop: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      mute |=> !o_out_switch) else $error("switching in mute");
   a_flt_latch: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      stby_b && mon && ot |=> fault_q[amf_pkg::FB_OT]) else $error("ot not latched");
   a_sub_inc: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      stby_b && is_q == I_MACK && rise |=> sub_q == $past(sub_q) + 8'd1)
      else $error("no increment");
   a_no_oc_mute: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      st_q == amf_pkg::ST_MUTE |-> !chan_flt) else $error("oc watched in mute");
   c_play: cover property (@(posedge i_sys_clk) st_q == amf_pkg::ST_PLAY);
   c_seq_rd: cover property (@(posedge i_sys_clk) is_q == I_MACK ##[1:1000] is_q == I_TX);
   c_fault: cover property (@(posedge i_sys_clk) o_alert_oe);
endmodule : amf_ctrl

//--- testbench/amf_i2c_master.sv
// i2c bus master model standing in for the system processor
`timescale 1ns/10ps
module amf_i2c_master (
   input wire logic i_sys_clk,
   input wire logic i_sda, // resolved bus level
   output logic o_scl,
   output logic o_sda_oe // high while pulling sda low
);
   ////////////////////////////////////////////////////////////////////////////
   // idle bus released; scl is pushed, since the slave never stretches it
   initial begin
      o_scl = 1'b1;
      o_sda_oe = 1'b0;
   end
   // a third of a bit period (six clocks), long enough for the slave pin synchroniser
   task automatic hp;
      repeat (6) @(negedge i_sys_clk);
   endtask : hp
   // start or repeated start: sda falls while scl is high
   task automatic start;
      o_sda_oe = 1'b0;
      hp();
      o_scl = 1'b1;
      hp();
      o_sda_oe = 1'b1;
      hp();
      o_scl = 1'b0;
      hp();
   endtask : start
   // stop: sda rises while scl is high
   task automatic stop;
      o_sda_oe = 1'b1;
      hp();
      o_scl = 1'b1;
      hp();
      o_sda_oe = 1'b0;
      hp();
   endtask : stop
   // one bit; data is held over the whole high phase, sampled at its end
   task automatic bit_io(input logic b, output logic r);
      o_sda_oe = ~b;
      hp();
      o_scl = 1'b1;
      hp();
      r = i_sda;
      o_scl = 1'b0;
      hp();
   endtask : bit_io
   // eight data bits msb first, then the acknowledge slot
   task automatic byte_io(input logic [7:0] d, input logic nine, output logic [7:0] q,
                          output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
         q[i] = r;
      end
      bit_io(nine, r);
      ack = ~r;
   endtask : byte_io
   // address-only probe, returns whether the slave acknowledged
   task automatic probe(input logic [7:0] a, output logic ack);
      logic [7:0] q;
      start();
      byte_io(a, 1'b1, q, ack);
      stop();
   endtask : probe
   // random write of one byte
   task automatic write_reg(input logic [7:0] sub, input logic [7:0] d, output logic ok);
      logic [7:0] q;
      logic a0, a1, a2;
      start();
      byte_io(8'hD8, 1'b1, q, a0);
      byte_io(sub, 1'b1, q, a1);
      byte_io(d, 1'b1, q, a2);
      stop();
      ok = a0 & a1 & a2;
   endtask : write_reg
   // sequential read of n bytes; ack all but the last, then nack and stop
   task automatic read_seq(input logic [7:0] sub, input int n, output logic [7:0] q[4]);
      logic [7:0] t;
      logic a;
      start();
      byte_io(8'hD8, 1'b1, t, a);
      byte_io(sub, 1'b1, t, a);
      start();
      byte_io(8'hD9, 1'b1, t, a);
      for (int k = 0; k < n; k++) begin
         byte_io(8'hFF, (k == n - 1), q[k], a);
      end
      stop();
   endtask : read_seq
endmodule : amf_i2c_master

//--- testbench/amf_ctrl_tb.sv
// self-checking bench of the amplifier mode and fault controller
`timescale 1ns/10ps
module amf_ctrl_tb;
   logic clk = 1'b0; // 125 mhz system clock
   logic rst_b = 1'b0;
   logic standby_b = 1'b0; // start in standby
   logic mute = 1'b0; // kept low during standby
   logic [4:0] flt = 5'h00; // {dc, oc, ot, high, low}
   logic diag_done = 1'b0;
   logic [3:0] diag_res = 4'h0;
   logic scl, m_oe, s_oe, a_oe, osc, sw, bias, drun, ok;
   logic [7:0] ctrl;
   logic [7:0] q[4];
   logic [7:0] exp_f = 8'h00; // sticky fault bits expected
   wire sda = ~(m_oe | s_oe); // pulled up, wired-and
   int err_count = 0;
   int n_compared = 0;
   localparam int FB[5] = '{amf_pkg::FB_UV, amf_pkg::FB_OV, amf_pkg::FB_OT,
                            amf_pkg::FB_OC, amf_pkg::FB_DC};
   ////////////////////////////////////////////////////////////////////////////
   always #4 clk = ~clk;
   amf_ctrl #(.WAKE_CYCLES(20)) u_amf_ctrl (.i_sys_clk(clk), .i_rst_b(rst_b),
      .i_standby_b(standby_b), .i_mute(mute), .i_supply_low_fault(flt[0]),
      .i_supply_high_fault(flt[1]), .i_overtemp_shutdown(flt[2]),
      .i_overcurrent_shutdown(flt[3]), .i_dc_offset(flt[4]), .i_diag_done(diag_done),
      .i_diag_result(diag_res), .i_scl(scl), .i_sda(sda), .o_sda_oe(s_oe), .o_sda_out(),
      .o_alert_oe(a_oe), .o_alert_out(), .o_osc_en(osc), .o_out_switch(sw),
      .o_out_bias(bias), .o_diag_run(drun), .o_ctrl(ctrl));
   amf_i2c_master u_amf_i2c_master (.i_sys_clk(clk), .i_sda(sda), .o_scl(scl),
      .o_sda_oe(m_oe));
   ////////////////////////////////////////////////////////////////////////////
   // compare and count
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : tally_and_finish
   // leave standby, check the diagnostic state, then end it with a result
   task automatic wake_diag(input logic [3:0] r);
      standby_b = 1'b1;
      repeat (40) @(negedge clk);
      chk("bias in diag", 8'h01, bias);
      chk("osc in diag", 8'h01, osc);
      diag_res = r;
      diag_done = 1'b1;
      @(negedge clk);
      diag_done = 1'b0;
      repeat (8) @(negedge clk);
   endtask : wake_diag
   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (2) @(negedge clk);
      rst_b = 1'b1;
      @(negedge clk);
      chk("ctrl reset", amf_pkg::CTRL_RST, ctrl);
      chk("osc standby", 8'h00, osc);
      u_amf_i2c_master.probe(8'hD8, ok);
      chk("ack in standby", 8'h00, ok);
      wake_diag(4'h0);
      mute = 1'b1;
      repeat (8) @(negedge clk);
      chk("switch muted", 8'h00, sw);
      chk("osc muted", 8'h01, osc);
      mute = 1'b0;
      repeat (8) @(negedge clk);
      chk("switch play", 8'h01, sw);
      u_amf_i2c_master.probe(8'hDA, ok);
      chk("foreign addr", 8'h00, ok);
      u_amf_i2c_master.write_reg(8'h03, 8'h5A, ok);
      chk("write ack", 8'h01, ok);
      chk("ctrl pins", 8'h5A, ctrl);
      u_amf_i2c_master.write_reg(8'h01, 8'hFF, ok);
      u_amf_i2c_master.read_seq(8'h01, 4, q);
      chk("fault reg", 8'h00, q[0]);
      chk("status reg", 8'h80, q[1]);
      chk("ctrl reg", 8'h5A, q[2]);
      chk("past end", amf_pkg::UNMAPPED_VAL, q[3]);
      mute = 1'b1;
      repeat (8) @(negedge clk);
      flt[3] = 1'b1;
      repeat (8) @(negedge clk);
      chk("oc in mute", 8'h00, a_oe);
      flt = 5'h00;
      mute = 1'b0;
      repeat (8) @(negedge clk);
      // each protection fault in play, one at a time
      for (int k = 0; k < 5; k++) begin
         flt[k] = 1'b1;
         exp_f[FB[k]] = 1'b1;
         repeat (8) @(negedge clk);
         chk("alert on", 8'h01, a_oe);
         chk("hard mute", 8'h00, sw);
         flt = 5'h00;
         repeat (8) @(negedge clk);
         chk("alert off", 8'h00, a_oe);
      end
      u_amf_i2c_master.read_seq(8'h01, 1, q);
      chk("fault cause", exp_f, q[0]);
      standby_b = 1'b0;
      repeat (8) @(negedge clk);
      chk("ctrl standby", amf_pkg::CTRL_RST, ctrl);
      chk("switch standby", 8'h00, sw);
      chk("osc stopped", 8'h00, osc);
      wake_diag(4'b1000);
      chk("diag rerun", 8'h01, drun);
      u_amf_i2c_master.read_seq(8'h01, 2, q);
      chk("diag fault", 8'h04, q[0]);
      chk("short status", 8'h01, q[1][amf_pkg::SB_SHORT]);
      tally_and_finish();
   end
   // watchdog well beyond the expected run length
   initial begin
      #400_000;
      err_count++;
      $display("watchdog expired");
      tally_and_finish();
   end
endmodule : amf_ctrl_tb
